// ===== core/gpb_regs.vh
// What this block does
// - bit 0 one means input, zero output
// - bit 1 one inverts the pin signal
// - bit 7 selects open drain or push-pull
// - bit 2 routes pin to its peripheral
// - pins 1.6/1.7 feed joystick B RC inputs
// - pin 2.0 carries keyboard port bit 7
// - pin 2.1 two-bit selector: floppy, edge, kbc
// - pin 2.2 two-bit selector: motor, edge, kbc
// - edge interrupt inputs fire on both edges
// - offset 2E reads zero, writes ignored
// - pin 2.4 has no alternate function
// - pins 3.0-3.3: fan tachs and speed outputs
// - standby reset loads 0x01 by default
// - pins 3.2/3.3 load 0x00 on main/hard reset
// - pin 3.4 loads 0x05 on standby reset
// - pin 3.5 loads 0x04 on every reset
`ifndef GPB_REGS_VH
`define GPB_REGS_VH

`define GPB_NPINS      15
`define GPB_OFS_P16    8'h29
`define GPB_OFS_P17    8'h2A
`define GPB_OFS_P20    8'h2B
`define GPB_OFS_P21    8'h2C
`define GPB_OFS_P22    8'h2D
`define GPB_OFS_RSVD   8'h2E
`define GPB_OFS_P24    8'h2F
`define GPB_OFS_P25    8'h30
`define GPB_OFS_P26    8'h31
`define GPB_OFS_P27    8'h32
`define GPB_OFS_P30    8'h33
`define GPB_OFS_P31    8'h34
`define GPB_OFS_P32    8'h35
`define GPB_OFS_P33    8'h36
`define GPB_OFS_P34    8'h37
`define GPB_OFS_P35    8'h38
`define GPB_OFS_STAT   8'h40
`define GPB_OFS_MASK   8'h41

`define GPB_DIR_BIT    0
`define GPB_INV_BIT    1
`define GPB_SEL_BIT    2
`define GPB_OD_BIT     7

`define GPB_SEL_GPIO   2'h0
`define GPB_SEL_KBC    2'h1
`define GPB_SEL_EDGE   2'h2
`define GPB_SEL_FDD    2'h3

`define GPB_WMASK_ONE  8'h87
`define GPB_WMASK_TWO  8'h8F
`define GPB_WMASK_NONE 8'h83

`define GPB_RST_DFLT   8'h01
`define GPB_RST_P34    8'h05
`define GPB_RST_P35    8'h04
`define GPB_RST_FAN    8'h00

`define GPB_IX_P16     0
`define GPB_IX_P17     1
`define GPB_IX_P20     2
`define GPB_IX_P21     3
`define GPB_IX_P22     4
`define GPB_IX_P24     5
`define GPB_IX_P25     6
`define GPB_IX_P26     7
`define GPB_IX_P27     8
`define GPB_IX_P30     9
`define GPB_IX_P31     10
`define GPB_IX_P32     11
`define GPB_IX_P33     12
`define GPB_IX_P34     13
`define GPB_IX_P35     14
`define GPB_IX_NONE    4'hF

`endif

// ===== core/gpb_pin.v
`timescale 1ns/1ps
module gpb_pin (
    // clock and reset
    input  wire core_clk_i,
    input  wire rst_n_i,
    // configuration
    input  wire dir_in_i,
    input  wire inv_i,
    input  wire od_i,
    // internal side
    input  wire dout_i,
    output wire din_o,
    // pad side
    input  wire pad_i,
    output wire pad_o,
    output wire pad_oe_o
);
    reg  s1_r;
    reg  s2_r;
    reg  din_r;
    reg  pad_r;
    reg  oe_r;
    wire pv;

    assign pv       = dout_i ^ inv_i;
    assign din_o    = din_r;
    assign pad_o    = pad_r;
    assign pad_oe_o = oe_r;

    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_r  <= 1'b0;
            s2_r  <= 1'b0;
            din_r <= 1'b0;
            pad_r <= 1'b0;
            oe_r  <= 1'b0;
        end else begin
            s1_r  <= pad_i;
            s2_r  <= s1_r;
            din_r <= s2_r ^ inv_i;
            if (dir_in_i) begin
                pad_r <= 1'b0;
                oe_r  <= 1'b0;
            end else if (od_i) begin
                // open drain only ever pulls low
                pad_r <= 1'b0;
                oe_r  <= ~pv;
            end else begin
                pad_r <= pv;
                oe_r  <= 1'b1;
            end
        end
    end
endmodule // gpb_pin

// ===== core/gpb_edge.v
`timescale 1ns/1ps
module gpb_edge (
    // clock and reset
    input  wire core_clk_i,
    input  wire rst_n_i,
    // level in, event out
    input  wire en_i,
    input  wire lvl_i,
    output wire evt_o
);
    reg prev_r;
    reg evt_r;

    assign evt_o = evt_r;

    // prev tracks even while disabled so enabling never fires falsely
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_r <= 1'b0;
            evt_r  <= 1'b0;
        end else begin
            prev_r <= lvl_i;
            evt_r  <= en_i & (lvl_i ^ prev_r);
        end
    end
endmodule // gpb_edge

// ===== core/gpb_bank.v
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`include "gpb_regs.vh"
module gpb_bank (
    // clock and resets
    input  wire        core_clk_i,
    input  wire        rst_n_i,
    input  wire        main_pwr_rst_i,
    input  wire        hard_rst_i,
    // register port
    input  wire [7:0]  reg_addr_i,
    input  wire [7:0]  reg_wdata_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    output wire [7:0]  reg_rdata_o,
    // interrupt
    output wire        irq_o,
    // pads
    input  wire [14:0] pad_in_i,
    output wire [14:0] pad_out_o,
    output wire [14:0] pad_oe_o,
    // gpio data side
    input  wire [14:0] gpio_dout_i,
    output wire [14:0] gpio_din_o,
    // peripheral drives toward pins
    input  wire        kbc_port_bit_7_drv_i,
    input  wire        kbc_port_bit_6_drv_i,
    input  wire        kbc_port_bit_2_drv_i,
    input  wire        floppy_drive_select_b_n_i,
    input  wire        floppy_motor_on_b_n_i,
    input  wire        music_serial_tx_i,
    input  wire        sys_mgmt_irq_n_i,
    input  wire        fan_a_speed_out_i,
    input  wire        fan_b_speed_out_i,
    input  wire        infrared_tx_alt_i,
    // pin values toward peripherals
    output wire        joy_b_x_axis_rc_o,
    output wire        joy_b_y_axis_rc_o,
    output wire        kbc_port_bit_7_o,
    output wire        kbc_port_bit_6_o,
    output wire        kbc_port_bit_2_o,
    output wire        music_serial_rx_o,
    output wire        fan_a_tach_in_o,
    output wire        fan_b_tach_in_o,
    output wire        infrared_rx_alt_o
);
    localparam NP = `GPB_NPINS;
    localparam [8*NP-1:0] CFG_RST = {`GPB_RST_P35, `GPB_RST_P34,
                                     {13{`GPB_RST_DFLT}}};

    reg  [8*NP-1:0] cfg_r;
    reg  [8*NP-1:0] cfg_nxt;
    reg  [1:0]      stat_r;
    reg  [1:0]      stat_nxt;
    reg  [1:0]      mask_r;
    reg  [1:0]      mask_nxt;
    reg             irq_r;
    reg  [7:0]      rdata_r;
    reg  [7:0]      rd_val;
    reg  [3:0]      wr_ix;
    reg  [3:0]      rd_ix;
    reg  [1:0]      mrst_s1_r;
    reg  [1:0]      mrst_s2_r;
    reg  [NP-1:0]   alt_sel;
    reg  [NP-1:0]   pin_src;
    reg  [1:0]      sel21;
    reg  [1:0]      sel22;
    reg             joy_x_r;
    reg             joy_y_r;
    reg             kbc7_r;
    reg             kbc6_r;
    reg             kbc2_r;
    reg             mrx_r;
    reg             tach_a_r;
    reg             tach_b_r;
    reg             irrx_r;
    wire [NP-1:0]   din;
    wire [1:0]      evt;
    wire            mrst_w;

    // pin index for a register offset; 2E falls through as none
    function [3:0] ix_of;
        input [7:0] a;
        reg   [7:0] d;
        begin
            ix_of = `GPB_IX_NONE;
            if (a >= `GPB_OFS_P16 && a <= `GPB_OFS_P22) begin
                d = a - `GPB_OFS_P16;
                ix_of = d[3:0];
            end else if (a >= `GPB_OFS_P24 && a <= `GPB_OFS_P35) begin
                d = a - `GPB_OFS_P24 + 8'h05;
                ix_of = d[3:0];
            end
        end
    endfunction

    // reserved bits are not stored so they always read zero
    function [7:0] wmask_of;
        input [3:0] ix;
        begin
            if (ix == `GPB_IX_P21 || ix == `GPB_IX_P22)
                wmask_of = `GPB_WMASK_TWO;
            else if (ix == `GPB_IX_P24)
                wmask_of = `GPB_WMASK_NONE;
            else
                wmask_of = `GPB_WMASK_ONE;
        end
    endfunction

    assign reg_rdata_o = rdata_r;
    assign irq_o       = irq_r;
    assign gpio_din_o  = din;
    assign mrst_w      = |mrst_s2_r;

    assign joy_b_x_axis_rc_o = joy_x_r;
    assign joy_b_y_axis_rc_o = joy_y_r;
    assign kbc_port_bit_7_o  = kbc7_r;
    assign kbc_port_bit_6_o  = kbc6_r;
    assign kbc_port_bit_2_o  = kbc2_r;
    assign music_serial_rx_o = mrx_r;
    assign fan_a_tach_in_o   = tach_a_r;
    assign fan_b_tach_in_o   = tach_b_r;
    assign infrared_rx_alt_o = irrx_r;

    // configuration register next state
    always @* begin
        cfg_nxt = cfg_r;
        wr_ix   = ix_of(reg_addr_i);
        if (reg_wr_i && wr_ix != `GPB_IX_NONE)
            cfg_nxt[{wr_ix, 3'h0} +: 8] = reg_wdata_i & wmask_of(wr_ix);
        // main power or hard reset overrides a coincident write
        if (mrst_w) begin
            cfg_nxt[8*`GPB_IX_P32 +: 8] = `GPB_RST_FAN;
            cfg_nxt[8*`GPB_IX_P33 +: 8] = `GPB_RST_FAN;
            cfg_nxt[8*`GPB_IX_P35 +: 8] = `GPB_RST_P35;
        end
    end

    // function routing
    always @* begin
        sel21   = cfg_r[8*`GPB_IX_P21+`GPB_SEL_BIT +: 2];
        sel22   = cfg_r[8*`GPB_IX_P22+`GPB_SEL_BIT +: 2];
        alt_sel = {NP{1'b0}};
        pin_src = gpio_dout_i;
        alt_sel[`GPB_IX_P16] = cfg_r[8*`GPB_IX_P16+`GPB_SEL_BIT];
        alt_sel[`GPB_IX_P17] = cfg_r[8*`GPB_IX_P17+`GPB_SEL_BIT];
        alt_sel[`GPB_IX_P20] = cfg_r[8*`GPB_IX_P20+`GPB_SEL_BIT];
        alt_sel[`GPB_IX_P21] = (sel21 != `GPB_SEL_GPIO);
        alt_sel[`GPB_IX_P22] = (sel22 != `GPB_SEL_GPIO);
        alt_sel[`GPB_IX_P25] = cfg_r[8*`GPB_IX_P25+`GPB_SEL_BIT];
        alt_sel[`GPB_IX_P26] = cfg_r[8*`GPB_IX_P26+`GPB_SEL_BIT];
        alt_sel[`GPB_IX_P27] = cfg_r[8*`GPB_IX_P27+`GPB_SEL_BIT];
        alt_sel[`GPB_IX_P30] = cfg_r[8*`GPB_IX_P30+`GPB_SEL_BIT];
        alt_sel[`GPB_IX_P31] = cfg_r[8*`GPB_IX_P31+`GPB_SEL_BIT];
        alt_sel[`GPB_IX_P32] = cfg_r[8*`GPB_IX_P32+`GPB_SEL_BIT];
        alt_sel[`GPB_IX_P33] = cfg_r[8*`GPB_IX_P33+`GPB_SEL_BIT];
        alt_sel[`GPB_IX_P34] = cfg_r[8*`GPB_IX_P34+`GPB_SEL_BIT];
        alt_sel[`GPB_IX_P35] = cfg_r[8*`GPB_IX_P35+`GPB_SEL_BIT];
        // input-only functions leave the gpio data on the output path
        if (alt_sel[`GPB_IX_P20])
            pin_src[`GPB_IX_P20] = kbc_port_bit_7_drv_i;
        case (sel21)
            `GPB_SEL_FDD:
                pin_src[`GPB_IX_P21] = floppy_drive_select_b_n_i;
            `GPB_SEL_KBC:
                pin_src[`GPB_IX_P21] = kbc_port_bit_6_drv_i;
            default:
                pin_src[`GPB_IX_P21] = gpio_dout_i[`GPB_IX_P21];
        endcase
        case (sel22)
            `GPB_SEL_FDD:
                pin_src[`GPB_IX_P22] = floppy_motor_on_b_n_i;
            `GPB_SEL_KBC:
                pin_src[`GPB_IX_P22] = kbc_port_bit_2_drv_i;
            default:
                pin_src[`GPB_IX_P22] = gpio_dout_i[`GPB_IX_P22];
        endcase
        if (alt_sel[`GPB_IX_P26])
            pin_src[`GPB_IX_P26] = music_serial_tx_i;
        if (alt_sel[`GPB_IX_P27])
            pin_src[`GPB_IX_P27] = sys_mgmt_irq_n_i;
        if (alt_sel[`GPB_IX_P32])
            pin_src[`GPB_IX_P32] = fan_b_speed_out_i;
        if (alt_sel[`GPB_IX_P33])
            pin_src[`GPB_IX_P33] = fan_a_speed_out_i;
        if (alt_sel[`GPB_IX_P35])
            pin_src[`GPB_IX_P35] = infrared_tx_alt_i;
    end

    genvar g;
    generate
        for (g = 0; g < NP; g = g + 1) begin : pin
            gpb_pin u_pin (
                .core_clk_i (core_clk_i),
                .rst_n_i    (rst_n_i),
                .dir_in_i   (cfg_r[8*g+`GPB_DIR_BIT]),
                .inv_i      (cfg_r[8*g+`GPB_INV_BIT]),
                .od_i       (cfg_r[8*g+`GPB_OD_BIT]),
                .dout_i     (pin_src[g]),
                .din_o      (din[g]),
                .pad_i      (pad_in_i[g]),
                .pad_o      (pad_out_o[g]),
                .pad_oe_o   (pad_oe_o[g])
            );
        end
    endgenerate

    gpb_edge u_edge0 (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .en_i       (sel21 == `GPB_SEL_EDGE),
        .lvl_i      (din[`GPB_IX_P21]),
        .evt_o      (evt[0])
    );

    gpb_edge u_edge1 (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .en_i       (sel22 == `GPB_SEL_EDGE),
        .lvl_i      (din[`GPB_IX_P22]),
        .evt_o      (evt[1])
    );

    // register reads, status clear on read, mask writes
    always @* begin
        rd_ix    = ix_of(reg_addr_i);
        rd_val   = 8'h00;
        stat_nxt = stat_r;
        mask_nxt = mask_r;
        if (rd_ix != `GPB_IX_NONE)
            rd_val = cfg_r[{rd_ix, 3'h0} +: 8];
        else if (reg_addr_i == `GPB_OFS_STAT)
            rd_val = {6'h00, stat_r};
        else if (reg_addr_i == `GPB_OFS_MASK)
            rd_val = {6'h00, mask_r};
        if (reg_rd_i && reg_addr_i == `GPB_OFS_STAT)
            stat_nxt = 2'h0;
        // a new event in the clearing cycle survives
        stat_nxt = stat_nxt | evt;
        if (reg_wr_i && reg_addr_i == `GPB_OFS_MASK)
            mask_nxt = reg_wdata_i[1:0];
    end

    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_r     <= CFG_RST;
            stat_r    <= 2'h0;
            mask_r    <= 2'h0;
            irq_r     <= 1'b0;
            rdata_r   <= 8'h00;
            mrst_s1_r <= 2'h0;
            mrst_s2_r <= 2'h0;
        end else begin
            cfg_r     <= cfg_nxt;
            stat_r    <= stat_nxt;
            mask_r    <= mask_nxt;
            irq_r     <= |(stat_nxt & mask_nxt);
            rdata_r   <= reg_rd_i ? rd_val : 8'h00;
            mrst_s1_r <= {hard_rst_i, main_pwr_rst_i};
            mrst_s2_r <= mrst_s1_r;
        end
    end

    // unselected function inputs idle high, like a pulled-up pin
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            joy_x_r  <= 1'b1;
            joy_y_r  <= 1'b1;
            kbc7_r   <= 1'b1;
            kbc6_r   <= 1'b1;
            kbc2_r   <= 1'b1;
            mrx_r    <= 1'b1;
            tach_a_r <= 1'b1;
            tach_b_r <= 1'b1;
            irrx_r   <= 1'b1;
        end else begin
            joy_x_r  <= alt_sel[`GPB_IX_P16] ? din[`GPB_IX_P16] : 1'b1;
            joy_y_r  <= alt_sel[`GPB_IX_P17] ? din[`GPB_IX_P17] : 1'b1;
            kbc7_r   <= alt_sel[`GPB_IX_P20] ? din[`GPB_IX_P20] : 1'b1;
            kbc6_r   <= (sel21 == `GPB_SEL_KBC) ? din[`GPB_IX_P21] : 1'b1;
            kbc2_r   <= (sel22 == `GPB_SEL_KBC) ? din[`GPB_IX_P22] : 1'b1;
            mrx_r    <= alt_sel[`GPB_IX_P25] ? din[`GPB_IX_P25] : 1'b1;
            tach_b_r <= alt_sel[`GPB_IX_P30] ? din[`GPB_IX_P30] : 1'b1;
            tach_a_r <= alt_sel[`GPB_IX_P31] ? din[`GPB_IX_P31] : 1'b1;
            irrx_r   <= alt_sel[`GPB_IX_P34] ? din[`GPB_IX_P34] : 1'b1;
        end
    end
endmodule // gpb_bank

// ===== test/gpb_bank_asserts.sv
`timescale 1ns/1ps
module gpb_bank_asserts (
    // clock and resets
    input wire        core_clk_i,
    input wire        rst_n_i,
    input wire        main_pwr_rst_i,
    input wire        hard_rst_i,
    // register port
    input wire [7:0]  reg_addr_i,
    input wire [7:0]  reg_wdata_i,
    input wire        reg_wr_i,
    input wire        reg_rd_i,
    input wire [7:0]  reg_rdata_o,
    // pads
    input wire [14:0] pad_out_o,
    input wire [14:0] pad_oe_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_rd(a);
        reg_rd_i && reg_addr_i == a;
    endsequence
    sequence s_cfg_20;
        reg_wr_i && reg_addr_i == 8'h2B;
    endsequence
    // six cycles cover the two sync flops and the pad update
    sequence s_pwr_held;
        (main_pwr_rst_i || hard_rst_i)[*6];
    endsequence

    property p_rsvd_read;
        s_rd(8'h2E) |=> reg_rdata_o == 8'h00;
    endproperty
    a_rsvd_read: assert property (p_rsvd_read)
        else $error("reserved offset read not zero");
    property p_one_sel_rsvd;
        s_rd(8'h2B) |=> reg_rdata_o[6:3] == 4'h0;
    endproperty
    a_one_sel_rsvd: assert property (p_one_sel_rsvd)
        else $error("reserved bits of pin 2.0 read set");
    property p_two_sel_rsvd;
        (s_rd(8'h2C) or s_rd(8'h2D)) |=> reg_rdata_o[6:4] == 3'h0;
    endproperty
    a_two_sel_rsvd: assert property (p_two_sel_rsvd)
        else $error("reserved bits of two-bit selector pin set");
    property p_no_sel_rsvd;
        s_rd(8'h2F) |=> reg_rdata_o[6:2] == 5'h00;
    endproperty
    a_no_sel_rsvd: assert property (p_no_sel_rsvd)
        else $error("pin 2.4 reserved bits read set");
    property p_dir_in;
        s_cfg_20 ##0 reg_wdata_i[0] |-> ##2 !pad_oe_o[2];
    endproperty
    a_dir_in: assert property (p_dir_in)
        else $error("input pin still driven");
    property p_push_pull;
        s_cfg_20 ##0 !(reg_wdata_i[7] || reg_wdata_i[0]) |-> ##2 pad_oe_o[2];
    endproperty
    a_push_pull: assert property (p_push_pull)
        else $error("push-pull output not driven");
    property p_open_drain;
        s_cfg_20 ##0 (reg_wdata_i[7] && !reg_wdata_i[0])
            |-> ##2 !pad_out_o[2];
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open drain pin drives high");
    property p_pwr_rst;
        s_pwr_held |-> pad_oe_o[11] && pad_oe_o[12] && pad_oe_o[14];
    endproperty
    a_pwr_rst: assert property (p_pwr_rst)
        else $error("fan or infrared pin not output after reset");
    property p_rst_idle;
        $rose(rst_n_i) |=> pad_oe_o == 15'h4000;
    endproperty
    a_rst_idle: assert property (p_rst_idle)
        else $error("wrong pins driven right after reset");
endmodule // gpb_bank_asserts

bind gpb_bank gpb_bank_asserts chk_u (.core_clk_i, .rst_n_i,
    .main_pwr_rst_i, .hard_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .pad_out_o, .pad_oe_o);

// ===== test/gpb_pad_model.sv
`timescale 1ns/1ps
module gpb_pad_model (
    // from the bank
    input  wire [14:0] pad_out_i,
    input  wire [14:0] pad_oe_i,
    // board levels
    input  wire [14:0] ext_lvl_i,
    // resolved pins
    output wire [14:0] pad_lvl_o
);
    // a released pin shows the board level, never the last driven one
    assign pad_lvl_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_lvl_i);
endmodule // gpb_pad_model

// ===== test/testbench.sv
`timescale 1ns/1ps
module testbench;
    reg         core_clk_i = 1'b0;
    reg         rst_n_i = 1'b0;
    reg         main_pwr_rst_i = 1'b0;
    reg         hard_rst_i = 1'b0;
    reg  [7:0]  reg_addr_i = 8'h00;
    reg  [7:0]  reg_wdata_i = 8'h00;
    reg         reg_wr_i = 1'b0;
    reg         reg_rd_i = 1'b0;
    reg  [14:0] ext_lvl = 15'h0000;
    reg  [14:0] gpio_dout_i = 15'h0000;
    reg  [9:0]  drv = 10'h3FF;
    wire [7:0]  reg_rdata_o;
    wire        irq_o;
    wire [14:0] pad_in_i, pad_out_o, pad_oe_o, gpio_din_o;
    wire [8:0]  fo;
    int         error_cnt = 0, num_checks = 0, seed, i, a;
    logic [7:0] rv, d;
    logic       s, eo, eout;
    logic [31:0] e;
    logic [31:0] tab_in [9] = '{32'h29050000, 32'h2A050101, 32'h2B050202,
        32'h2C050303, 32'h2D050404, 32'h30050605, 32'h33050906,
        32'h34050A07, 32'h37050D08};
    logic [31:0] tab_out [10] = '{32'h2B040200, 32'h2C040301, 32'h2D040402,
        32'h2C0C0303, 32'h2D0C0404, 32'h31040705, 32'h32040806,
        32'h36040C07, 32'h35040B08, 32'h38040E09};
    logic [7:0] pcfg [6] = '{8'h01, 8'h03, 8'h00, 8'h02, 8'h80, 8'h82};

    gpb_bank dut_u (.core_clk_i, .rst_n_i, .main_pwr_rst_i, .hard_rst_i,
        .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .irq_o, .pad_in_i, .pad_out_o, .pad_oe_o, .gpio_dout_i, .gpio_din_o,
        .kbc_port_bit_7_drv_i(drv[0]), .kbc_port_bit_6_drv_i(drv[1]),
        .kbc_port_bit_2_drv_i(drv[2]), .floppy_drive_select_b_n_i(drv[3]),
        .floppy_motor_on_b_n_i(drv[4]), .music_serial_tx_i(drv[5]),
        .sys_mgmt_irq_n_i(drv[6]), .fan_a_speed_out_i(drv[7]),
        .fan_b_speed_out_i(drv[8]), .infrared_tx_alt_i(drv[9]),
        .joy_b_x_axis_rc_o(fo[0]), .joy_b_y_axis_rc_o(fo[1]),
        .kbc_port_bit_7_o(fo[2]), .kbc_port_bit_6_o(fo[3]),
        .kbc_port_bit_2_o(fo[4]), .music_serial_rx_o(fo[5]),
        .fan_b_tach_in_o(fo[6]), .fan_a_tach_in_o(fo[7]),
        .infrared_rx_alt_o(fo[8]));
    gpb_pad_model pads_u (.pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o),
        .ext_lvl_i(ext_lvl), .pad_lvl_o(pad_in_i));

    always #4 core_clk_i = ~core_clk_i;

    function logic [7:0] rst_val(input logic [7:0] x);
        if (x == 8'h2E) return 8'h00;
        if (x == 8'h37) return 8'h05;
        if (x == 8'h38) return 8'h04;
        return 8'h01;
    endfunction
    function logic [7:0] wmask(input logic [7:0] x);
        case (x)
            8'h2E: return 8'h00;
            8'h2C, 8'h2D: return 8'h8F;
            8'h2F: return 8'h83;
            default: return 8'h87;
        endcase
    endfunction

    task check(input string nm, input logic [15:0] seen,
               input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task wr(input logic [7:0] x, input logic [7:0] v);
        @(posedge core_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= x;
        reg_wdata_i <= v;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task rdc(input logic [7:0] x, input logic [7:0] exp);
        @(posedge core_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= x;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1 check("register read", reg_rdata_o, exp);
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        #200000;
        error_cnt++;
        wrap_up();
    end

    initial begin
        seed = $urandom(458);
        repeat (3) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        for (a = 8'h29; a <= 8'h38; a++)
            rdc(8'(a), rst_val(8'(a)));
        for (a = 8'h29; a <= 8'h38; a++) begin
            d = 8'($urandom);
            wr(8'(a), d);
            rdc(8'(a), d & wmask(8'(a)));
        end
        wr(8'h50, 8'hFF);
        rdc(8'h50, 8'h00);
        for (i = 0; i < 2; i++) begin
            wr(8'h35, 8'h81);
            wr(8'h38, 8'h01);
            wr(8'h33, 8'h83);
            @(posedge core_clk_i);
            main_pwr_rst_i <= (i == 0);
            hard_rst_i <= (i == 1);
            cyc(8);
            @(posedge core_clk_i);
            main_pwr_rst_i <= 1'b0;
            hard_rst_i <= 1'b0;
            cyc(3);
            rdc(8'h35, 8'h00);
            rdc(8'h36, 8'h00);
            rdc(8'h38, 8'h04);
            rdc(8'h33, 8'h83);
        end
        foreach (pcfg[k]) begin
            d = pcfg[k];
            wr(8'h2B, d);
            @(posedge core_clk_i);
            gpio_dout_i <= 15'($urandom);
            ext_lvl <= 15'($urandom);
            cyc(6);
            s = d[1] ^ gpio_dout_i[2];
            eo = d[0] ? 1'b0 : (d[7] ? ~s : 1'b1);
            eout = (d[0] | d[7]) ? 1'b0 : s;
            check("pin oe", pad_oe_o[2], eo);
            check("pin out", pad_out_o[2], eout);
            rv = {7'h00, (eo ? eout : ext_lvl[2]) ^ d[1]};
            check("pin din", gpio_din_o[2], rv);
        end
        foreach (tab_in[k]) begin
            e = tab_in[k];
            wr(e[31:24], e[23:16]);
            @(posedge core_clk_i);
            ext_lvl <= 15'($urandom);
            cyc(8);
            s = ext_lvl[e[15:8]];
            eo = fo[e[7:0]];
            check("alt in", eo, s);
        end
        foreach (tab_out[k]) begin
            e = tab_out[k];
            wr(e[31:24], e[23:16]);
            @(posedge core_clk_i);
            drv <= 10'($urandom);
            cyc(4);
            s = drv[e[7:0]];
            eo = pad_out_o[e[15:8]];
            check("alt out", eo, s);
        end
        // release the driven pins first so enabling sees a settled level
        wr(8'h2C, 8'h01);
        wr(8'h2D, 8'h01);
        cyc(6);
        wr(8'h2C, 8'h09);
        wr(8'h2D, 8'h09);
        wr(8'h41, 8'h03);
        cyc(8);
        rdc(8'h41, 8'h03);
        cyc(1);
        rdc(8'h40, 8'h00);
        for (i = 0; i < 4; i++) begin
            @(posedge core_clk_i);
            ext_lvl[3 + i % 2] <= ~ext_lvl[3 + i % 2];
            cyc(8);
            check("irq set", irq_o, 1'b1);
            rdc(8'h40, (i % 2) ? 8'h02 : 8'h01);
            cyc(3);
            check("irq clear", irq_o, 1'b0);
        end
        wr(8'h41, 8'h00);
        @(posedge core_clk_i);
        ext_lvl[3] <= ~ext_lvl[3];
        cyc(8);
        check("irq masked", irq_o, 1'b0);
        rdc(8'h40, 8'h01);
        wrap_up();
    end
endmodule // testbench
